// file: compact_timer.v
`include "timer_consts.vh"

module compact_timer (
    // clock and reset
    input  wire        mclk,
    input  wire        rst,
    // clock enables for the counter
    input  wire        tick_sys,
    input  wire        tick_sys_div4,
    input  wire        tick_hi_div16,
    input  wire        tick_hi_div64,
    input  wire        tick_sub,
    // register access, one-cycle strobes
    input  wire        wr_en,
    input  wire        rd_en,
    input  wire [4:0]  offset,
    input  wire [7:0]  wdata,
    output reg  [7:0]  rdata,
    // status
    output reg         match_a_flag,
    output reg         match_p_flag,
    // pins
    output reg         timer_output_pin,
    output reg         timer_output_pin_inverted
);

    reg  [7:0] ctrl0_reg;
    reg  [7:0] ctrl1_reg;
    reg  [9:0] count_reg;
    reg  [9:0] compare_a_value;
    reg  [7:0] low_buffer_reg;
    reg        run_prev_reg;
    reg        out_state_reg;

    wire [2:0] counter_clock_select = ctrl0_reg[`C0_CLK_HI:`C0_CLK_LO];
    wire [2:0] compare_p_period     = ctrl0_reg[`C0_PER_HI:`C0_PER_LO];
    wire [1:0] operating_mode_field = ctrl1_reg[`C1_MODE_HI:`C1_MODE_LO];
    wire [1:0] io_sel               = ctrl1_reg[`C1_IO_HI:`C1_IO_LO];
    wire       clear_source_select  = ctrl1_reg[`C1_CLR_SEL];
    wire       counter_run_control  = ctrl0_reg[`C0_RUN];
    wire       run_rise             = counter_run_control & ~run_prev_reg;

    reg tick;
    always @*
    begin
        case (counter_clock_select)
            `CK_SYS_DIV4: tick = tick_sys_div4;
            `CK_SYS:      tick = tick_sys;
            `CK_HI_DIV16: tick = tick_hi_div16;
            `CK_HI_DIV64: tick = tick_hi_div64;
            `CK_SUB_A:    tick = tick_sub;
            `CK_SUB_B:    tick = tick_sub;
            default:      tick = 1'b0;  // undefined codes freeze the count
        endcase
    end

    wire advance = tick & counter_run_control & ~ctrl0_reg[`C0_PAUSE];
    // p matches on the next count, so period n spans n*128 clocks
    wire [9:0] next_count = count_reg + 10'h001;
    // p compares top three bits, a compares all ten
    wire hit_p = advance && (compare_p_period == `PER_FULL ? count_reg == `CNT_MAX
                                                           : next_count == {compare_p_period, 7'h00});
    wire hit_a = advance && (count_reg == compare_a_value);
    wire overflow = advance && (count_reg == `CNT_MAX);

    // ****************************************
    // counter
    // ****************************************
    // free-running count, clears
    always @(posedge mclk)
    begin
        if (rst)
            count_reg <= `CNT_ZERO;
        else if (run_rise)
            count_reg <= `CNT_ZERO;
        // selected match clears counter, 000 means full overflow
        else if (overflow || (clear_source_select ? hit_a : hit_p))
            count_reg <= `CNT_ZERO;
        else if (advance)
            count_reg <= next_count;
    end

    // ****************************************
    // registers and byte pairing
    // ****************************************
    // byte pairs, buffer moves only on high byte read or compare a low write
    always @(posedge mclk)
    begin
        if (rst)
        begin
            ctrl0_reg       <= `BYTE_ZERO;
            ctrl1_reg       <= `BYTE_ZERO;
            compare_a_value <= `CNT_ZERO;
            low_buffer_reg  <= `BYTE_ZERO;
            run_prev_reg    <= 1'b0;
        end
        else
        begin
            run_prev_reg <= counter_run_control;
            if (wr_en)
            begin
                case (offset)
                    `OFS_CTRL0: ctrl0_reg <= wdata;
                    `OFS_CTRL1: ctrl1_reg <= wdata;
                    `OFS_CMPA_LOW: low_buffer_reg <= wdata;
                    `OFS_CMPA_HIGH: compare_a_value <= {wdata[1:0], low_buffer_reg};
                    default: ;
                endcase
            end
            if (rd_en && offset == `OFS_CNT_HIGH)
                low_buffer_reg <= count_reg[7:0];
            if (rd_en && offset == `OFS_CMPA_HIGH)
                low_buffer_reg <= compare_a_value[7:0];
        end
    end

    // read data, registered one cycle after the strobe
    always @(posedge mclk)
    begin
        if (rst)
            rdata <= `BYTE_ZERO;
        else if (rd_en)
        begin
            case (offset)
                `OFS_CTRL0:     rdata <= ctrl0_reg;
                `OFS_CTRL1:     rdata <= ctrl1_reg;
                `OFS_CNT_LOW:   rdata <= low_buffer_reg;
                `OFS_CMPA_LOW:  rdata <= low_buffer_reg;
                `OFS_CNT_HIGH:  rdata <= {6'h00, count_reg[9:8]};
                `OFS_CMPA_HIGH: rdata <= {6'h00, compare_a_value[9:8]};
                `OFS_STATUS:    rdata <= {6'h00, match_p_flag, match_a_flag};
                default:        rdata <= `BYTE_ZERO;
            endcase
        end
    end

    // ****************************************
    // match flags
    // ****************************************
    // separate sticky flags; set wins over write-one-clear
    wire clr_a = wr_en && offset == `OFS_STATUS && wdata[`ST_MATCH_A];
    wire clr_p = wr_en && offset == `OFS_STATUS && wdata[`ST_MATCH_P];
    always @(posedge mclk)
    begin
        if (rst)
        begin
            match_a_flag <= 1'b0;
            match_p_flag <= 1'b0;
        end
        else
        begin
            match_a_flag <= hit_a | (match_a_flag & ~clr_a);
            match_p_flag <= hit_p | (match_p_flag & ~clr_p);
        end
    end

    // ****************************************
    // output pin logic
    // ****************************************
    // mode dependent output; timer mode holds the pin
    always @(posedge mclk)
    begin
        if (rst)
            out_state_reg <= 1'b0;
        else if (run_rise)
            out_state_reg <= ctrl1_reg[`C1_INIT];
        else
        begin
            case (operating_mode_field)
                `MODE_CMP:
                begin
                    // set, clear or toggle on match a
                    if (hit_a)
                    begin
                        case (io_sel)
                            `IO_LOW:    out_state_reg <= 1'b0;
                            `IO_HIGH:   out_state_reg <= 1'b1;
                            `IO_TOGGLE: out_state_reg <= ~out_state_reg;
                            default:    out_state_reg <= out_state_reg;
                        endcase
                    end
                end
                `MODE_PWM:
                begin
                    // edge aligned: active from period start to duty match
                    case (io_sel)
                        `IO_NONE: out_state_reg <= 1'b0;
                        `IO_LOW:  out_state_reg <= 1'b1;
                        `IO_HIGH:
                        begin
                            if (hit_a)
                                out_state_reg <= 1'b0;
                            else if (count_reg == `CNT_ZERO && advance)
                                out_state_reg <= 1'b1;
                        end
                        default: out_state_reg <= out_state_reg;
                    endcase
                end
                default: out_state_reg <= out_state_reg;
            endcase
        end
    end

    // inverted pair, polarity applied to both
    always @(posedge mclk)
    begin
        if (rst)
        begin
            timer_output_pin          <= 1'b0;
            timer_output_pin_inverted <= 1'b1;
        end
        else
        begin
            timer_output_pin          <= out_state_reg ^ ctrl1_reg[`C1_POL];
            timer_output_pin_inverted <= ~(out_state_reg ^ ctrl1_reg[`C1_POL]);
        end
    end

endmodule

// file: timer_consts.vh
// How it works
// - three identical timer instances, each with own counter, compares, interrupts, pins
// - each timer flags compare A and compare P matches separately
// - counter runs freely from selected clock, compared against comparators continuously
// - a match may clear the counter and change the output pin
// - two pins per timer, second always inverse of first
// - compare output mode: match sets high, low, or toggles pin
// - pwm mode gives one edge-aligned waveform, duty or period adjustable
// - 3-bit field selects divided system, high internal or sub clock
// - counter and compare a appear as high/low byte pairs
// - compare a low write only fills the shared buffer
// - compare a high write loads high bits and buffered low byte
// - high byte read returns high bits and captures low byte into buffer
// - low byte read returns the buffer, not the live byte
// - buffer moves only on high byte read or compare a low write
// - modes: compare output, timer/counter, pwm output
// - primary output feeds matching led driver channel pwm input
// - 10-bit up-counter; p checks top three bits, a all ten
// - run bit rising clears counter; overflow or selected match also clears
// - mode field 00 compare, 10 pwm, 11 timer, 01 undefined
// - p matches at 128-clock multiples; period 000 runs full 1024 counts
`ifndef TIMER_CONSTS_VH
`define TIMER_CONSTS_VH

// ****************************************
// register map, byte addresses per timer
// ****************************************
`define TIMER_COUNT      3
`define TIMER_STRIDE     8'h20
`define OFS_CTRL0        5'h00
`define OFS_CTRL1        5'h04
`define OFS_CNT_LOW      5'h08
`define OFS_CNT_HIGH     5'h0c
`define OFS_CMPA_LOW     5'h10
`define OFS_CMPA_HIGH    5'h14
`define OFS_STATUS       5'h18

// ****************************************
// field positions
// ****************************************
`define C0_PAUSE         7
`define C0_CLK_HI        6
`define C0_CLK_LO        4
`define C0_RUN           3
`define C0_PER_HI        2
`define C0_PER_LO        0
`define C1_MODE_HI       7
`define C1_MODE_LO       6
`define C1_IO_HI         5
`define C1_IO_LO         4
`define C1_INIT          3
`define C1_POL           2
`define C1_CLR_SEL       0
`define ST_MATCH_A       0
`define ST_MATCH_P       1

// ****************************************
// encodings
// ****************************************
`define MODE_CMP         2'h0
`define MODE_PWM         2'h2
`define MODE_TMR         2'h3
`define IO_NONE          2'h0
`define IO_LOW           2'h1
`define IO_HIGH          2'h2
`define IO_TOGGLE        2'h3
`define CK_SYS_DIV4      3'h0
`define CK_SYS           3'h1
`define CK_HI_DIV16      3'h2
`define CK_HI_DIV64      3'h3
`define CK_SUB_A         3'h4
`define CK_SUB_B         3'h5
`define DIV4_MASK        8'h03
`define DIV16_MASK       8'h0f
`define DIV64_MASK       8'h3f
`define CNT_MAX          10'h3ff
`define CNT_ZERO         10'h000
`define PER_FULL         3'h0
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2
`define BYTE_ZERO        8'h00

`endif

// file: timer_unit.v
`include "timer_consts.vh"

module timer_unit (
    // clock and reset
    input  wire        mclk,
    input  wire        rst,
    // axi4-lite write address
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    // axi4-lite write data
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    // axi4-lite write response
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // axi4-lite read address
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    // axi4-lite read data
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // counter clock enables, one-cycle pulses from the clock unit
    input  wire        tick_sys_div4,
    input  wire        tick_hi_div16,
    input  wire        tick_hi_div64,
    input  wire        tick_sub,
    // output pins and led driver feeds
    output wire [2:0]  timer_output_pin,
    output wire [2:0]  timer_output_pin_inverted,
    output reg  [2:0]  led_driver_channel,
    // match flags, levels
    output wire [2:0]  match_a_flag,
    output wire [2:0]  match_p_flag
);

    // ****************************************
    // axi4-lite slave
    // ****************************************
    reg  [7:0]  aw_addr_reg;
    reg  [7:0]  w_data_reg;
    reg         aw_have_reg;
    reg         w_have_reg;
    reg         w_lane_reg;
    reg  [7:0]  ar_addr_reg;
    reg         rd_wait_reg;
    reg         rd_load_reg;
    wire [7:0]  sub_rdata [0:2];

    // unit index: 0..2 valid, 3 and offsets above status unmapped
    function [1:0] unit_of;
        input [7:0] a;
        begin
            unit_of = a[6:5];
        end
    endfunction

    function mapped;
        input [7:0] a;
        begin
            mapped = (a[7] == 1'b0) && (a[6:5] != 2'h3) && (a[4:0] <= `OFS_STATUS) && (a[1:0] == 2'h0);
        end
    endfunction

    wire wr_fire = aw_have_reg && w_have_reg && !s_axi_bvalid;
    wire rd_fire = rd_wait_reg;

    // write channels taken in either order, response after both
    always @(posedge mclk)
    begin
        if (rst)
        begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `RESP_OKAY;
            aw_have_reg   <= 1'b0;
            w_have_reg    <= 1'b0;
            aw_addr_reg   <= 8'h00;
            w_data_reg    <= `BYTE_ZERO;
            w_lane_reg    <= 1'b0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_addr_reg   <= s_axi_awaddr;
                aw_have_reg   <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_data_reg   <= s_axi_wdata[7:0];
                w_lane_reg   <= s_axi_wstrb[0];  // only the low lane carries data
                w_have_reg   <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= mapped(aw_addr_reg) ? `RESP_OKAY : `RESP_SLVERR;
                aw_have_reg  <= 1'b0;
                w_have_reg   <= 1'b0;
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // read: address taken, strobe, byte registered, then rvalid with data
    always @(posedge mclk)
    begin
        if (rst)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rresp   <= `RESP_OKAY;
            s_axi_rdata   <= 32'h0000_0000;
            ar_addr_reg   <= 8'h00;
            rd_wait_reg   <= 1'b0;
            rd_load_reg   <= 1'b0;
        end
        else
        begin
            rd_wait_reg <= 1'b0;
            rd_load_reg <= rd_fire;
            if (s_axi_arvalid && s_axi_arready)
            begin
                ar_addr_reg   <= s_axi_araddr;
                s_axi_arready <= 1'b0;
                rd_wait_reg   <= 1'b1;
            end
            // rvalid waits for the unit's registered byte, so data never lags valid
            if (rd_load_reg)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= mapped(ar_addr_reg) ? `RESP_OKAY : `RESP_SLVERR;
                s_axi_rdata  <= mapped(ar_addr_reg) ? {24'h000000, sub_rdata[unit_of(ar_addr_reg)]} : 32'h0000_0000;
            end
            if (s_axi_rvalid && s_axi_rready)
            begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // ****************************************
    // timer instances
    // ****************************************
    // three identical timers
    genvar i;
    generate
        for (i = 0; i < `TIMER_COUNT; i = i + 1)
        begin : g_unit
            wire sel_w = wr_fire && w_lane_reg && mapped(aw_addr_reg) && unit_of(aw_addr_reg) == i;
            wire sel_r = rd_fire && mapped(ar_addr_reg) && unit_of(ar_addr_reg) == i;
            compact_timer u_timer (
                .mclk                      (mclk),
                .rst                       (rst),
                .tick_sys                  (1'b1),
                .tick_sys_div4             (tick_sys_div4),
                .tick_hi_div16             (tick_hi_div16),
                .tick_hi_div64             (tick_hi_div64),
                .tick_sub                  (tick_sub),
                .wr_en                     (sel_w),
                .rd_en                     (sel_r),
                .offset                    (sel_w ? aw_addr_reg[4:0] : ar_addr_reg[4:0]),
                .wdata                     (w_data_reg),
                .rdata                     (sub_rdata[i]),
                .match_a_flag              (match_a_flag[i]),
                .match_p_flag              (match_p_flag[i]),
                .timer_output_pin          (timer_output_pin[i]),
                .timer_output_pin_inverted (timer_output_pin_inverted[i])
            );
        end
    endgenerate

    // primary output feeds the led driver channel
    always @(posedge mclk)
    begin
        if (rst)
            led_driver_channel <= 3'h0;
        else
            led_driver_channel <= timer_output_pin;
    end

endmodule

// file: tick_source.sv
module tick_source (
    // clock and reset
    input  wire        mclk,
    input  wire        rst,
    // enable pulses, one mclk wide
    output logic       tick_sys_div4,
    output logic       tick_hi_div16,
    output logic       tick_hi_div64,
    output logic       tick_sub
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [5:0] div_reg;
    // free-running divider; phases unrelated to bus traffic
    always @(posedge mclk)
    begin
        div_reg <= rst ? 6'h00 : div_reg + 6'h01;
    end
    assign tick_sys_div4 = div_reg[1:0] == 2'h3;
    assign tick_hi_div16 = div_reg[3:0] == 4'hf;
    assign tick_hi_div64 = div_reg == 6'h3f;
    assign tick_sub      = div_reg[2:0] == 3'h7;
endmodule

// file: timer_unit_properties.sv
module timer_unit_properties (
    // clock and reset
    input wire       mclk,
    input wire       rst,
    // bus handshakes
    input wire       s_axi_awvalid,
    input wire       s_axi_awready,
    input wire       s_axi_wvalid,
    input wire       s_axi_wready,
    input wire       s_axi_bvalid,
    input wire       s_axi_bready,
    input wire       s_axi_arvalid,
    input wire       s_axi_arready,
    input wire       s_axi_rvalid,
    input wire       s_axi_rready,
    // pins and flags
    input wire [2:0] timer_output_pin,
    input wire [2:0] timer_output_pin_inverted,
    input wire [2:0] led_driver_channel,
    input wire [2:0] match_a_flag,
    input wire [2:0] match_p_flag
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);
    // ****************
    // bus steps
    // ****************
    sequence write_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence read_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    // answers come in bounded time and stand until taken
    a_write_answer:
    assert property (write_taken |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
    a_read_answer:
    assert property (read_taken |-> ##[2:3] s_axi_rvalid) else $error("read answer late");
    a_bvalid_stands:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
    a_rvalid_stands:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid) else $error("rvalid dropped");
    // pin pair and led feed
    a_pin_inverse:
    assert property (timer_output_pin_inverted == ~timer_output_pin) else $error("pins not inverse");
    a_led_follows_pin:
    assert property (!$past(rst) |-> led_driver_channel == $past(timer_output_pin)) else $error("led feed wrong");
    // flags only fall while a write is under way
    a_flag_a_sticky:
    assert property ((|($past(match_a_flag) & ~match_a_flag)) |-> !s_axi_wready || s_axi_bvalid || $past(s_axi_bvalid))
        else $error("a flag lost");
    a_flag_p_sticky:
    assert property ((|($past(match_p_flag) & ~match_p_flag)) |-> !s_axi_wready || s_axi_bvalid || $past(s_axi_bvalid))
        else $error("p flag lost");
    a_reset_idle:
    assert property ($fell(rst) |-> timer_output_pin == 3'h0 && match_a_flag == 3'h0) else $error("reset state wrong");
endmodule

bind timer_unit timer_unit_properties chk_u (.mclk(mclk), .rst(rst), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .timer_output_pin(timer_output_pin), .timer_output_pin_inverted(timer_output_pin_inverted),
    .led_driver_channel(led_driver_channel), .match_a_flag(match_a_flag), .match_p_flag(match_p_flag));

// file: timer_unit_test.sv
`include "timer_consts.vh"
module timer_unit_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  s_axi_awaddr = 8'h00;
    logic [7:0]  s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_awvalid = 1'b0;
    logic        s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0;
    wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire  [1:0]  s_axi_bresp, s_axi_rresp;
    wire  [31:0] s_axi_rdata;
    wire         tick_sys_div4, tick_hi_div16, tick_hi_div64, tick_sub;
    wire  [2:0]  timer_output_pin, timer_output_pin_inverted, led_driver_channel, match_a_flag, match_p_flag;
    int          miscompares = 0;
    int          tests_run = 0;
    int          n, h, l, d;
    logic [7:0]  b;
    // 40 MHz
    always #12.5 mclk = ~mclk;
    timer_unit dut_u (.mclk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tick_sys_div4, .tick_hi_div16,
        .tick_hi_div64, .tick_sub, .timer_output_pin, .timer_output_pin_inverted, .led_driver_channel,
        .match_a_flag, .match_p_flag);
    tick_source ticks_u (.mclk, .rst, .tick_sys_div4, .tick_hi_div16, .tick_hi_div64, .tick_sub);
    // ****************
    // shared tasks
    // ****************
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // address and data offered together, bready held until the answer
    task automatic wr(input logic [7:0] a, input logic [7:0] dat, input logic [1:0] er = `RESP_OKAY);
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, dat};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge mclk);
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        check(s_axi_bresp, er);
    endtask
    // rready held from the request until rvalid is seen
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er = `RESP_OKAY);
        @(posedge mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge mclk);
            if (s_axi_arvalid && s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        check(s_axi_rresp, er);
        if (er == `RESP_OKAY)
            check(s_axi_rdata, exp);
    endtask
    // cycles the timer 2 pin stays at one level, bounded
    task automatic span(input logic lvl, output int c);
        c = 0;
        while (timer_output_pin[2] === lvl && c < 4000)
        begin
            @(posedge mclk);
            c++;
        end
    endtask
    task automatic finish_test();
        if (miscompares == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // hang guard, well past the longest clock-source pass
    initial
    begin
        #1500000;
        miscompares++;
        finish_test();
    end
    // ****************
    // main sequence
    // ****************
    initial
    begin
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        // control reset values of all three timers
        for (int t = 0; t < 3; t++)
        begin
            b = 8'(t) << 5;
            rdc(b + `OFS_CTRL0, 32'h0);
            rdc(b + `OFS_CTRL1, 32'h0);
        end
        // low byte write buffered, pair transfer on high access
        wr(8'h20 + `OFS_CMPA_LOW, 8'h5a);
        rdc(8'h20 + `OFS_CMPA_HIGH, 32'h0);
        rdc(8'h20 + `OFS_CMPA_LOW, 32'h0);
        wr(8'h20 + `OFS_CMPA_LOW, 8'ha5);
        wr(8'h20 + `OFS_CMPA_HIGH, 8'hfe);
        rdc(8'h20 + `OFS_CMPA_HIGH, 32'h2);
        rdc(8'h20 + `OFS_CMPA_LOW, 32'ha5);
        wr(8'h20 + `OFS_CMPA_LOW, 8'h33);
        rdc(8'h20 + `OFS_CNT_LOW, 32'h33);
        rdc(8'h20 + `OFS_CMPA_HIGH, 32'h2);
        rdc(8'h20 + `OFS_CMPA_LOW, 32'ha5);
        // every compare-output action, match on A at 0x010
        wr(`OFS_CMPA_LOW, 8'h10);
        wr(`OFS_CMPA_HIGH, 8'h00);
        for (int i = 0; i < 4; i++)
        begin
            wr(`OFS_CTRL0, 8'h00);
            wr(`OFS_STATUS, 8'h03);
            wr(`OFS_CTRL1, {`MODE_CMP, 2'(i), i == 1, 3'h1});
            wr(`OFS_CTRL0, 8'h18);
            repeat (2) @(posedge mclk);
            check(timer_output_pin[0], i == 1);
            n = 0;
            while (match_a_flag[0] !== 1'b1 && n < 3000)
            begin
                @(posedge mclk);
                n++;
            end
            @(posedge mclk);
            check(timer_output_pin[0], i >> 1);
            check(timer_output_pin_inverted[0], !(i >> 1));
        end
        rdc(`OFS_CNT_HIGH, 32'h0);
        check(match_p_flag[0], 1'b0);
        rdc(`OFS_STATUS, 32'h1);
        // each clock source, timer mode, p match at 128 counts
        wr(8'h20 + `OFS_CTRL1, {`MODE_TMR, 6'h00});
        for (int c = 0; c < 6; c++)
        begin
            d = (c == 0) ? 4 : (c == 1) ? 1 : (c == 2) ? 16 : (c == 3) ? 64 : 8;
            wr(8'h20 + `OFS_CTRL0, 8'h00);
            wr(8'h20 + `OFS_STATUS, 8'h03);
            wr(8'h20 + `OFS_CTRL0, {1'b0, 3'(c), 4'h9});
            n = 0;
            while (match_p_flag[1] !== 1'b1 && n < 20000)
            begin
                @(posedge mclk);
                n++;
            end
            check(n >= 127 * d && n <= 129 * d + 16, 1'b1);
        end
        // edge-aligned pwm, duty 0x40, period 128 then full count
        wr(8'h40 + `OFS_CMPA_LOW, 8'h40);
        wr(8'h40 + `OFS_CMPA_HIGH, 8'h00);
        wr(8'h40 + `OFS_CTRL1, {`MODE_PWM, `IO_HIGH, 4'h0});
        for (int p = 1; p >= 0; p--)
        begin
            wr(8'h40 + `OFS_CTRL0, 8'h00);
            wr(8'h40 + `OFS_CTRL0, {5'h3, 3'(p)});
            span(1'b0, l);
            span(1'b1, h);
            span(1'b0, l);
            span(1'b1, h);
            span(1'b0, l);
            check(h, 64);
            check(h + l, p ? 128 : 1024);
        end
        // paused restart holds zero; high read captures it
        wr(8'h40 + `OFS_CTRL0, 8'h00);
        wr(8'h40 + `OFS_CTRL1, {`MODE_PWM, `IO_HIGH, 4'h4});
        wr(8'h40 + `OFS_CTRL0, 8'h98);
        repeat (200) @(posedge mclk);
        check(timer_output_pin[2], 1'b1);
        rdc(8'h40 + `OFS_CNT_HIGH, 32'h0);
        rdc(8'h40 + `OFS_CNT_LOW, 32'h0);
        // unmapped places refused
        wr(8'h60, 8'h01, `RESP_SLVERR);
        rdc(8'h1c, 32'h0, `RESP_SLVERR);
        finish_test();
    end
endmodule
